/* File: dv/dcsp_codec_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dcsp_codec_model (
  // bench control
  input wire logic go_in,
  input wire logic [3:0] wlen_in,
  input wire logic [63:0] tx_in,
  output logic done_out,
  output logic [63:0] rx_out,
  // serial pins
  input wire logic sdo_in,
  output logic sck_out,
  output logic fs_out,
  output logic sdi_out
);
  logic busy = 1'b0;
  logic q;
  initial begin
    sck_out = 1'b0;
    fs_out = 1'b0;
    sdi_out = 1'b0;
    done_out = 1'b0;
    rx_out = '0;
  end
  // data line means nothing between frames, so keep it moving
  always #350 if (!busy) sdi_out = ~sdi_out;
  // we source an 800 ns bit clock that stands still between bursts
  task automatic bit_period(input logic d);
    sdi_out = d;
    #400 sck_out = 1'b1;
    q = sdo_in;
    #400 sck_out = 1'b0;
  endtask
  always @(posedge go_in) begin
    busy = 1'b1;
    done_out = 1'b0;
    // keep our edges half a system clock away from the edge that samples them
    #50;
    repeat (2) begin
      fs_out = 1'b1;
      bit_period(~sdi_out);
      fs_out = 1'b0;
      for (int w = 0; w < 4; w++) begin
        rx_out[w * 16 +: 16] = 16'h0000;
        for (int b = 0; b <= wlen_in; b++) begin
          bit_period(tx_in[w * 16 + 15 - b]);
          rx_out[w * 16 + 15 - b] = q;
        end
      end
    end
    busy = 1'b0;
    done_out = 1'b1;
  end
endmodule
`default_nettype wire

/* File: dv/dcsp_core_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module dcsp_core_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register bus
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // serial pins
  input wire logic bit_clock_pin_out,
  input wire logic bit_clock_pin_oe_out,
  input wire logic serial_data_out_pin_oe_out,
  input wire logic frame_sync_pin_out,
  input wire logic frame_sync_pin_oe_out
);
  logic [7:0] aw_q;
  logic [7:0] ar_q;
  logic [31:0] w_q;
  logic [31:0] ctrl_q;
  logic pend;
  logic [2:0] cnt;
  wire logic en = ctrl_q[dcsp_pkg::CTRL_EN_BIT];
  wire logic ckd = ctrl_q[dcsp_pkg::CTRL_CKD_BIT];
  wire logic fsd = ctrl_q[dcsp_pkg::CTRL_FSD_BIT];
  wire logic idl = ctrl_q[dcsp_pkg::CTRL_IDLE_BIT];
  function automatic logic mapped(input logic [7:0] a, input logic rd);
    return a[1:0] == 2'h0 && (a <= 8'h04 || a[7:4] == 4'h1 || (rd && (a == 8'h08 || a[7:4] == 4'h2)));
  endfunction
  always_ff @(posedge clk_in) begin
    if (s_axi_awvalid_in && s_axi_awready_out) aw_q <= s_axi_awaddr_in;
    if (s_axi_wvalid_in && s_axi_wready_out) w_q <= s_axi_wdata_in;
    if (s_axi_arvalid_in && s_axi_arready_out) ar_q <= s_axi_araddr_in;
  end
  // shadow of the control word, judged only once a write has fully settled
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= dcsp_pkg::CTRL_RESET;
    end else if (s_axi_bvalid_out && s_axi_bready_in && aw_q == dcsp_pkg::CTRL_OFS) begin
      ctrl_q <= w_q;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend <= 1'b0;
      cnt <= 3'h0;
    end else begin
      pend <= (pend || s_axi_awvalid_in) && !(s_axi_bvalid_out && s_axi_bready_in);
      cnt <= (pend || s_axi_awvalid_in || s_axi_wvalid_in || s_axi_bvalid_out) ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_ck_dir;
    cnt == 3'h7 |-> bit_clock_pin_oe_out == (en && !ckd);
  endproperty
  a_ck_dir: assert property (p_ck_dir) else $error("bit clock direction wrong");
  property p_fs_dir;
    cnt == 3'h7 |-> frame_sync_pin_oe_out == (en && !fsd);
  endproperty
  a_fs_dir: assert property (p_fs_dir) else $error("frame sync direction wrong");
  property p_do_idle;
    cnt == 3'h7 && en && !idl |-> serial_data_out_pin_oe_out;
  endproperty
  a_do_idle: assert property (p_do_idle) else $error("data out not driven");
  property p_dis_stop;
    cnt == 3'h7 && !en |=> $stable(bit_clock_pin_out) && $stable(frame_sync_pin_out);
  endproperty
  a_dis_stop: assert property (p_dis_stop) else $error("clock runs while disabled");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_map;
    s_axi_bvalid_out |-> s_axi_bresp_out == (mapped(aw_q, 1'b0) ? dcsp_pkg::RESP_OKAY : dcsp_pkg::RESP_SLVERR);
  endproperty
  a_b_map: assert property (p_b_map) else $error("write response code wrong");
  property p_r_map;
    s_axi_rvalid_out |-> s_axi_rresp_out == (mapped(ar_q, 1'b1) ? dcsp_pkg::RESP_OKAY : dcsp_pkg::RESP_SLVERR);
  endproperty
  a_r_map: assert property (p_r_map) else $error("read response code wrong");
endmodule
bind dcsp_core dcsp_core_asserts i_dcsp_core_asserts (.clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .bit_clock_pin_out, .bit_clock_pin_oe_out, .serial_data_out_pin_oe_out,
  .frame_sync_pin_out, .frame_sync_pin_oe_out);
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_in, rstn_in, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, go, done, prev;
  logic ck_o, ck_oe, do_o, do_oe, fs_o, fs_oe, m_ck, m_fs, m_di;
  logic [7:0] aw_a, ar_a;
  logic [31:0] wd, rdata, rd_d, n;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wsm;
  logic [15:0] msk;
  logic [15:0] cw [4];
  logic [63:0] m_tx, m_rx;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] ctl [8] = '{32'h0f01, 32'h0f11, 32'h0f21, 32'h0f31, 32'h0f08, 32'h0f03, 32'h0f07, 32'h0f0f};
  logic [2:0] oex [8] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h0, 3'h3, 3'h1, 3'h0};
  wire logic ck_w = ck_oe ? ck_o : m_ck;
  wire logic fs_w = fs_oe ? fs_o : m_fs;
  wire logic do_w = do_oe ? do_o : 1'bz;
  dcsp_core i_dcsp_core (.clk_in(clk_in), .rstn_in(rstn_in), .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .bit_clock_pin_in(ck_w),
    .bit_clock_pin_out(ck_o), .bit_clock_pin_oe_out(ck_oe), .serial_data_out_pin_out(do_o),
    .serial_data_out_pin_oe_out(do_oe), .serial_data_in_pin_in(m_di), .frame_sync_pin_in(fs_w),
    .frame_sync_pin_out(fs_o), .frame_sync_pin_oe_out(fs_oe));
  dcsp_codec_model i_dcsp_codec_model (.go_in(go), .wlen_in(wsm), .tx_in(m_tx), .done_out(done), .rx_out(m_rx),
    .sdo_in(do_w), .sck_out(m_ck), .fs_out(m_fs), .sdi_out(m_di));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    aw_a <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    ar_a <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // run needs about 2100 cycles; the margin covers a slow but legal design
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    {rstn_in, awv, wv, br, arv, rr, go} = 7'h00;
    {aw_a, ar_a, wd, wsm, m_tx} = '0;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(dcsp_pkg::CTRL_OFS, rd_d, resp);
    chk(rd_d, dcsp_pkg::CTRL_RESET);
    rd(dcsp_pkg::FRAME_OFS, rd_d, resp);
    chk(rd_d, dcsp_pkg::FRAME_RESET);
    rd(dcsp_pkg::STAT_OFS, rd_d, resp);
    chk(rd_d, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      wr(dcsp_pkg::CTRL_OFS, ctl[i], resp);
      repeat (8) @(posedge clk_in);
      chk({29'h0, ck_oe, fs_oe, do_oe}, {29'h0, oex[i]});
      n = 0;
      prev = ck_w;
      repeat (40) begin
        @(posedge clk_in);
        n += {31'h0, ck_w !== prev};
        prev = ck_w;
      end
      chk(n, oex[i][2] ? 32'd20 : 32'd0);
      $display("pin direction test %0d done", i);
    end
    wr(dcsp_pkg::FRAME_OFS, 32'h0000_0103, resp);
    for (int k = 0; k < 2; k++) begin
      wsm = k ? 4'h7 : 4'hf;
      msk = k ? 16'hff00 : 16'hffff;
      wr(dcsp_pkg::CTRL_OFS, 32'h0000_000e, resp);
      for (int w = 0; w < 4; w++) begin
        cw[w] = 16'hc3a5 + 16'(w) * 16'h1357;
        m_tx[w * 16 +: 16] = 16'h5e37 + 16'(w) * 16'h0f0f;
        wr(dcsp_pkg::TXB_OFS + 8'(4 * w), {16'h0, cw[w]}, resp);
      end
      wr(dcsp_pkg::CTRL_OFS, {20'h0, wsm, 8'h0f}, resp);
      repeat (4) @(posedge clk_in);
      go <= 1'b1;
      @(posedge clk_in);
      while (!done) @(posedge clk_in);
      go <= 1'b0;
      for (int w = 0; w < 4; w++) begin
        rd(dcsp_pkg::RXB_OFS + 8'(4 * w), rd_d, resp);
        chk(rd_d, {16'h0, m_tx[w * 16 +: 16] & msk});
        chk({16'h0, m_rx[w * 16 +: 16]}, {16'h0, cw[w] & msk});
      end
      $display("slave transfer test %0d done", k);
    end
    wr(dcsp_pkg::CTRL_OFS, 32'h0000_000e, resp);
    rd(dcsp_pkg::STAT_OFS, rd_d, resp);
    chk(rd_d & 32'h0000_002f, 32'h0000_0000);
    wr(8'h40, 32'h0000_1234, resp);
    chk_resp(resp, dcsp_pkg::RESP_SLVERR);
    wr(dcsp_pkg::RXB_OFS, 32'h0000_1234, resp);
    chk_resp(resp, dcsp_pkg::RESP_SLVERR);
    rd(8'h40, rd_d, resp);
    chk_resp(resp, dcsp_pkg::RESP_SLVERR);
    $display("access test done");
    end_sim();
  end
endmodule
`default_nettype wire

/* File: hw/dcsp_core.sv */
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dcsp_core #(
  parameter int WORD_W = dcsp_pkg::WORD_W,
  parameter int DEPTH = dcsp_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // serial pins
  input wire logic bit_clock_pin_in,
  output logic bit_clock_pin_out,
  output logic bit_clock_pin_oe_out,
  output logic serial_data_out_pin_out,
  output logic serial_data_out_pin_oe_out,
  input wire logic serial_data_in_pin_in,
  input wire logic frame_sync_pin_in,
  output logic frame_sync_pin_out,
  output logic frame_sync_pin_oe_out
);
  localparam int AW = $clog2(DEPTH);

  dcsp_pkg::dcsp_ctrl_s ctrl_reg;
  logic [3:0] frame_len_reg;
  logic [7:0] clk_div_reg;
  logic [WORD_W-1:0] tx_buf_reg [DEPTH];
  logic [WORD_W-1:0] rx_buf_reg [DEPTH];
  // shadow memory: low half receive, high half transmit
  logic [WORD_W-1:0] shadow_reg [2*DEPTH];
  logic [AW-1:0] ptr_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] slot_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic ck_gen_reg;
  logic in_frame_reg;
  logic fs_gen_reg;
  // a slave has seen its sync and waits for the bit clock period that carries it to end
  logic armed_reg;
  logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
  logic di_s1_reg, di_s2_reg;
  logic fs_s1_reg, fs_s2_reg, fs_prev_reg;
  logic [31:0] frames_done_reg;

  function automatic logic [AW:0] buf_addr(input logic top, input logic [AW-1:0] p);
    buf_addr = {top, p};
  endfunction

  function automatic logic [WORD_W-1:0] wlen_mask(input logic [3:0] wl);
    logic [WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < WORD_W; i++) begin
      if (i >= WORD_W - 1 - int'(wl)) begin
        m[i] = 1'b1;
      end
    end
    wlen_mask = m;
  endfunction

  // ---------------- axi4-lite slave ----------------
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_ok;
  wire logic do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  wire logic [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= dcsp_pkg::RESP_OKAY;
    end else begin
      s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out <= !w_held_reg && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_ok ? dcsp_pkg::RESP_OKAY : dcsp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // only word-aligned addresses in the control, frame and transmit areas take writes
  always_comb begin
    wr_ok = (aw_addr_reg == dcsp_pkg::CTRL_OFS) || (aw_addr_reg == dcsp_pkg::FRAME_OFS) ||
            (aw_addr_reg[7:4] == dcsp_pkg::TXB_OFS[7:4] && aw_addr_reg[1:0] == 2'h0 &&
             int'(aw_addr_reg[3:2]) < DEPTH);
  end

  // control registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg <= dcsp_pkg::dcsp_ctrl_s'(dcsp_pkg::CTRL_RESET[11:0]);
      frame_len_reg <= dcsp_pkg::FRAME_RESET[3:0];
      clk_div_reg <= dcsp_pkg::FRAME_RESET[15:8];
    end else if (do_write) begin
      if (aw_addr_reg == dcsp_pkg::CTRL_OFS) begin
        ctrl_reg <= dcsp_pkg::dcsp_ctrl_s'(12'((w_data_reg & wmask) | ({20'h0, ctrl_reg} & ~wmask)));
      end else if (aw_addr_reg == dcsp_pkg::FRAME_OFS) begin
        if (w_strb_reg[0]) frame_len_reg <= w_data_reg[dcsp_pkg::FRAME_LEN_LSB +: 4];
        if (w_strb_reg[1]) clk_div_reg <= w_data_reg[dcsp_pkg::FRAME_DIV_LSB +: 8];
      end
    end
  end

  // cpu-facing transmit buffer; the serial engine only reads it, while it writes rx_buf_reg directly
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) tx_buf_reg[i] <= '0;
    end else if (do_write && aw_addr_reg[7:4] == dcsp_pkg::TXB_OFS[7:4] && wr_ok) begin
      if (w_strb_reg[0]) tx_buf_reg[aw_addr_reg[2+:AW]][7:0] <= w_data_reg[7:0];
      if (w_strb_reg[1]) tx_buf_reg[aw_addr_reg[2+:AW]][15:8] <= w_data_reg[15:8];
    end
  end

  // read channel
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= dcsp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out && s_axi_arvalid_in;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= dcsp_pkg::RESP_OKAY;
        s_axi_rdata_out <= 32'h0000_0000;
        if (s_axi_araddr_in == dcsp_pkg::CTRL_OFS) begin
          s_axi_rdata_out <= {20'h0, ctrl_reg};
        end else if (s_axi_araddr_in == dcsp_pkg::FRAME_OFS) begin
          s_axi_rdata_out <= {16'h0, clk_div_reg, 4'h0, frame_len_reg};
        end else if (s_axi_araddr_in == dcsp_pkg::STAT_OFS) begin
          s_axi_rdata_out <= {frames_done_reg[23:0], 2'h0, in_frame_reg, 1'b0, slot_cnt_reg[1:0], 2'(ptr_reg)};
        end else if (s_axi_araddr_in[1:0] == 2'h0 && int'(s_axi_araddr_in[3:2]) < DEPTH &&
                     s_axi_araddr_in[7:4] == dcsp_pkg::TXB_OFS[7:4]) begin
          s_axi_rdata_out <= {16'h0, tx_buf_reg[s_axi_araddr_in[2+:AW]]};
        end else if (s_axi_araddr_in[1:0] == 2'h0 && int'(s_axi_araddr_in[3:2]) < DEPTH &&
                     s_axi_araddr_in[7:4] == dcsp_pkg::RXB_OFS[7:4]) begin
          s_axi_rdata_out <= {16'h0, rx_buf_reg[s_axi_araddr_in[2+:AW]]};
        end else begin
          s_axi_rresp_out <= dcsp_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ---------------- pin synchronisers ----------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      di_s1_reg <= 1'b0;
      di_s2_reg <= 1'b0;
      fs_s1_reg <= 1'b0;
      fs_s2_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
    end else begin
      ck_s1_reg <= bit_clock_pin_in;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      di_s1_reg <= serial_data_in_pin_in;
      di_s2_reg <= di_s1_reg;
      fs_s1_reg <= frame_sync_pin_in;
      fs_s2_reg <= fs_s1_reg;
      fs_prev_reg <= fs_s2_reg;
    end
  end

  // ---------------- bit clock ----------------
  wire logic en = ctrl_reg.interface_enable;
  wire logic ext_ck = ctrl_reg.bit_clock_direction;
  logic ck_rise, ck_fall;
  always_comb begin
    if (ext_ck) begin
      ck_rise = ck_s2_reg && !ck_s3_reg;
      ck_fall = !ck_s2_reg && ck_s3_reg;
    end else begin
      ck_rise = (div_cnt_reg == clk_div_reg) && !ck_gen_reg;
      ck_fall = (div_cnt_reg == clk_div_reg) && ck_gen_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_reg <= 8'h00;
      ck_gen_reg <= 1'b0;
    end else if (!en || ext_ck) begin
      div_cnt_reg <= 8'h00;
      ck_gen_reg <= 1'b0;
    end else if (div_cnt_reg == clk_div_reg) begin
      div_cnt_reg <= 8'h00;
      ck_gen_reg <= !ck_gen_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // ---------------- serial engine ----------------
  wire logic ac_mode = ctrl_reg.mode[1];
  wire logic i2s_mode = ctrl_reg.mode == dcsp_pkg::MODE_I2S;
  wire logic [3:0] wlen = ac_mode ? dcsp_pkg::AC_WLEN : ctrl_reg.word_size_field;
  wire logic [3:0] slots = ac_mode ? dcsp_pkg::AC_SLOT_WORDS : frame_len_reg;
  wire logic slave = ctrl_reg.frame_sync_direction;
  wire logic fs_sample = fs_s2_reg;
  wire logic word_end = bit_cnt_reg == wlen;
  wire logic frame_end = word_end && slot_cnt_reg == slots;
  // a short word ends at the bottom of the shifter; this many zeros lift its msb to the top
  wire logic [3:0] pad_bits = 4'(WORD_W - 1) - wlen;
  logic fs_start;
  always_comb begin
    if (i2s_mode) begin
      fs_start = fs_sample != fs_prev_reg;
    end else begin
      fs_start = fs_sample && !fs_prev_reg;
    end
  end
  wire logic [AW:0] rx_addr = buf_addr(1'b0, ptr_reg);
  wire logic [AW:0] tx_addr = buf_addr(1'b1, ptr_reg);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_reg <= '0;
      bit_cnt_reg <= 4'h0;
      slot_cnt_reg <= 4'h0;
      shift_reg <= '0;
      in_frame_reg <= 1'b0;
      fs_gen_reg <= 1'b0;
      frames_done_reg <= 32'h0000_0000;
      armed_reg <= 1'b0;
      for (int i = 0; i < 2*DEPTH; i++) shadow_reg[i] <= '0;
      for (int i = 0; i < DEPTH; i++) rx_buf_reg[i] <= '0;
    end else if (!en) begin
      ptr_reg <= '0;
      bit_cnt_reg <= 4'h0;
      slot_cnt_reg <= 4'h0;
      in_frame_reg <= 1'b0;
      fs_gen_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      if (!in_frame_reg && ck_fall && (!slave || armed_reg)) begin
        // slave data follows one bit clock after its sync; master frames start at once
        in_frame_reg <= 1'b1;
        armed_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        slot_cnt_reg <= 4'h0;
        shift_reg <= shadow_reg[tx_addr] & wlen_mask(wlen);
        fs_gen_reg <= i2s_mode ? !fs_gen_reg : 1'b1;
      end else if (in_frame_reg && ck_rise) begin
        shift_reg <= {shift_reg[WORD_W-2:0], di_s2_reg};
      end else if (in_frame_reg && ck_fall) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (!i2s_mode && !(ac_mode && slot_cnt_reg == 4'h0)) fs_gen_reg <= 1'b0;
        if (word_end) begin
          bit_cnt_reg <= 4'h0;
          shadow_reg[rx_addr] <= shift_reg << pad_bits;
          rx_buf_reg[ptr_reg] <= shift_reg << pad_bits;
          ptr_reg <= ptr_reg + 1'b1;
          slot_cnt_reg <= slot_cnt_reg + 4'h1;
          shift_reg <= shadow_reg[buf_addr(1'b1, ptr_reg + 1'b1)] & wlen_mask(wlen);
          if (i2s_mode && !slave) fs_gen_reg <= !fs_gen_reg;
          if (frame_end) begin
            in_frame_reg <= 1'b0;
            frames_done_reg <= frames_done_reg + 32'h1;
          end
        end
      end
      // a sync on the closing fall of a frame opens the next one, so back-to-back frames are kept;
      // any other sync inside a frame is ignored
      if (slave && fs_start && (!in_frame_reg || (ck_fall && frame_end))) begin
        armed_reg <= 1'b1;
      end
      // refresh transmit shadow from cpu copy for slots not in flight
      for (int i = 0; i < DEPTH; i++) begin
        if (!in_frame_reg || i != int'(ptr_reg)) shadow_reg[DEPTH + i] <= tx_buf_reg[i];
      end
    end
  end
  // ---------------- pin drivers ----------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_clock_pin_out <= 1'b0;
      bit_clock_pin_oe_out <= 1'b0;
      serial_data_out_pin_out <= 1'b0;
      serial_data_out_pin_oe_out <= 1'b0;
      frame_sync_pin_out <= 1'b0;
      frame_sync_pin_oe_out <= 1'b0;
    end else begin
      bit_clock_pin_out <= ck_gen_reg;
      bit_clock_pin_oe_out <= en && !ext_ck;
      frame_sync_pin_out <= fs_gen_reg;
      frame_sync_pin_oe_out <= en && !slave;
      serial_data_out_pin_out <= in_frame_reg && shift_reg[WORD_W-1];
      if (!en) begin
        serial_data_out_pin_oe_out <= 1'b0;
      end else begin
        serial_data_out_pin_oe_out <= in_frame_reg || !ctrl_reg.data_out_idle_select;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/dcsp_pkg.sv */
package dcsp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FRAME_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] TXB_OFS = 8'h10;
  localparam logic [7:0] RXB_OFS = 8'h20;
  // control and frame register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CKD_BIT = 1;
  localparam int CTRL_FSD_BIT = 2;
  localparam int CTRL_IDLE_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_WLEN_LSB = 8;
  localparam int FRAME_LEN_LSB = 0;
  localparam int FRAME_DIV_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0f00;
  localparam logic [31:0] FRAME_RESET = 32'h0000_0100;
  localparam int WORD_W = 16;
  localparam int PTR_W = 2;
  localparam int BUF_DEPTH = 4;
  localparam logic [3:0] AC_SLOT_WORDS = 4'hf;
  localparam logic [3:0] AC_WLEN = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_MULTI = 2'h0,
    MODE_I2S = 2'h1,
    MODE_AC16 = 2'h2,
    MODE_AC20 = 2'h3
  } dcsp_mode_e;

  typedef struct packed {
    logic [3:0] word_size_field;
    // bits 7:6 are unused; they keep every field at its register position
    logic [1:0] spare;
    dcsp_mode_e mode;
    logic data_out_idle_select;
    logic frame_sync_direction;
    logic bit_clock_direction;
    logic interface_enable;
  } dcsp_ctrl_s;

  typedef struct packed {
    logic o;
    logic oe;
  } dcsp_pin_s;
endpackage
